//--- rtl/sbrg_flag.sv
module sbrg_flag (
	// Clock and reset
	input  wire logic i_clk_sys,
	input  wire logic i_reset,
	// Event and acknowledge
	input  wire logic i_set,
	input  wire logic i_clr,
	// Sticky state
	output logic      o_flag
);

	typedef struct packed {
		logic flag_ff;
	} sbrg_flag_type;

	sbrg_flag_type s;
	sbrg_flag_type nxt_s;

	always_comb begin
		nxt_s = s;
		// Set wins over a write-one-to-clear in the same cycle
		nxt_s.flag_ff = i_set | (s.flag_ff & ~i_clr);
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			s <= '{flag_ff: 1'b0};
		end else begin
			s <= nxt_s;
		end
	end

	assign o_flag = s.flag_ff;

	set_wins_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		i_set |=> o_flag)
		else $error("Event lost against a clear");

endmodule

//--- rtl/sbrg_modcnt.sv
module sbrg_modcnt
	import sbrg_pkg::*;
#(
	parameter int W = 13
) (
	// Clock and reset
	input  wire logic         i_clk_sys,
	input  wire logic         i_reset,
	// Control
	input  wire logic         i_clr,
	input  wire logic         i_step,
	input  wire logic [W-1:0] i_modulus,
	// Wrap pulse
	output logic              o_wrap
);

	typedef struct packed {
		logic [W-1:0] cnt_ff;
		logic         wrap_ff;
	} sbrg_cnt_type;

	localparam sbrg_cnt_type CNT_RST = '{cnt_ff: '0, wrap_ff: 1'b0};

	sbrg_cnt_type s;
	sbrg_cnt_type nxt_s;
	logic         at_last;

	assign at_last = (s.cnt_ff == (i_modulus - W'(1)));

	always_comb begin
		nxt_s = s;
		nxt_s.wrap_ff = 1'b0;
		// Clear wins so a restart never leaks a stale pulse
		if (i_clr) begin
			nxt_s.cnt_ff = '0;
		end else if (i_step) begin
			if (at_last) begin
				nxt_s.cnt_ff  = '0;
				nxt_s.wrap_ff = 1'b1;
			end else begin
				nxt_s.cnt_ff = s.cnt_ff + W'(1);
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			s <= CNT_RST;
		end else begin
			s <= nxt_s;
		end
	end

	assign o_wrap = s.wrap_ff;

	cnt_range_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(i_modulus != '0) |-> (s.cnt_ff < i_modulus) || $past(i_modulus) != i_modulus)
		else $error("Divider count left its modulus range");

endmodule

//--- rtl/sbrg_pkg.sv
package sbrg_pkg;

	// Divisor geometry
	localparam int          SBRG_DIV_W        = 13;
	localparam int          SBRG_DIVH_W       = 5;
	localparam int          SBRG_DIVL_W       = 8;
	localparam int          SBRG_OVS_W        = 5;
	localparam logic [4:0]  SBRG_OVERSAMPLE   = 5'h10;

	// Register byte offsets on the bus
	localparam int          SBRG_ADDR_W       = 5;
	localparam logic [4:0]  SBRG_OFS_DIVH     = 5'h00;
	localparam logic [4:0]  SBRG_OFS_DIVL     = 5'h04;
	localparam logic [4:0]  SBRG_OFS_CTRL     = 5'h08;
	localparam logic [4:0]  SBRG_OFS_STAT     = 5'h0C;
	localparam logic [4:0]  SBRG_OFS_GEN      = 5'h10;

	// Field positions
	localparam int          SBRG_BIT_LBK_IE   = 7;
	localparam int          SBRG_BIT_RXE_IE   = 6;
	localparam int          SBRG_BIT_RSVD     = 5;
	localparam int          SBRG_BIT_RX_ON    = 0;
	localparam int          SBRG_BIT_TX_ON    = 1;
	localparam int          SBRG_BIT_RUN      = 0;
	localparam logic [7:0]  SBRG_DIVH_WMASK   = 8'hDF;

	// Reset values
	localparam logic [7:0]  SBRG_DIVH_RST     = 8'h00;
	localparam logic [7:0]  SBRG_DIVL_RST     = 8'h01;
	localparam logic [1:0]  SBRG_CTRL_RST     = 2'h0;

endpackage

//--- rtl/sbrg_top.sv
module sbrg_top
	import sbrg_pkg::*;
(
	// Clock and reset
	input  wire logic                   i_clk_sys,
	input  wire logic                   i_reset,
	// Avalon-MM slave
	input  wire logic [SBRG_ADDR_W-1:0] i_address,
	input  wire logic                   i_read,
	input  wire logic                   i_write,
	input  wire logic [31:0]            i_writedata,
	input  wire logic [3:0]             i_byteenable,
	output logic [31:0]                 o_readdata,
	output logic                        o_waitrequest,
	// Events from the receiver
	input  wire logic                   i_line_break_evt,
	input  wire logic                   i_rx_edge_evt,
	// Interrupt
	output logic                        o_irq,
	// Generator outputs
	output logic                        o_tick16,
	output logic                        o_bit_tick,
	output logic                        o_gen_run,
	output logic [SBRG_DIV_W-1:0]       o_divisor_value,
	// Serial enables
	output logic                        o_rx_on_bit,
	output logic                        o_tx_on_bit
);

	typedef struct packed {
		logic [7:0]             divh_buf_ff;
		logic [SBRG_DIVH_W-1:0] divh_work_ff;
		logic [SBRG_DIVL_W-1:0] divl_ff;
		logic [1:0]             ctrl_ff;
		logic                   armed_ff;
		logic                   run_ff;
		logic                   wait_ff;
		logic [31:0]            rdata_ff;
		logic                   irq_ff;
		logic                   tick16_ff;
		logic                   bit_tick_ff;
	} sbrg_state_type;

	localparam sbrg_state_type STATE_RST = '{
		divh_buf_ff:  SBRG_DIVH_RST,
		divh_work_ff: SBRG_DIVH_RST[SBRG_DIVH_W-1:0],
		divl_ff:      SBRG_DIVL_RST,
		ctrl_ff:      SBRG_CTRL_RST,
		armed_ff:     1'b0,
		run_ff:       1'b0,
		wait_ff:      1'b1,
		rdata_ff:     32'h0000_0000,
		irq_ff:       1'b0,
		tick16_ff:    1'b0,
		bit_tick_ff:  1'b0
	};

	sbrg_state_type s;
	sbrg_state_type nxt_s;

	logic                  req;
	logic                  acc_wr;
	logic                  wr_divh;
	logic                  wr_divl;
	logic                  wr_ctrl;
	logic                  wr_stat;
	logic                  rd_divh;
	logic                  cnt_clr;
	logic                  wrap16;
	logic                  wrap_bit;
	logic                  line_break_flag;
	logic                  rx_edge_flag;
	logic                  clr_lbk;
	logic                  clr_rxe;
	logic [SBRG_DIV_W-1:0] divisor_value;
	logic [31:0]           rd_mux;

	// One wait cycle per request, accepted on the edge where waitrequest is low
	assign req     = i_read | i_write;
	assign acc_wr  = i_write & ~s.wait_ff & i_byteenable[0];
	assign wr_divh = acc_wr & (i_address == SBRG_OFS_DIVH);
	assign wr_divl = acc_wr & (i_address == SBRG_OFS_DIVL);
	assign wr_ctrl = acc_wr & (i_address == SBRG_OFS_CTRL);
	assign wr_stat = acc_wr & (i_address == SBRG_OFS_STAT);
	assign rd_divh = i_read & s.wait_ff & (i_address == SBRG_OFS_DIVH);

	assign clr_lbk = wr_stat & i_writedata[SBRG_BIT_LBK_IE];
	assign clr_rxe = wr_stat & i_writedata[SBRG_BIT_RXE_IE];

	assign divisor_value = {s.divh_work_ff, s.divl_ff};

	// Restart on a new divisor keeps the first period exact
	assign cnt_clr = ~s.run_ff | wr_divl;

	sbrg_modcnt #(
		.W(SBRG_DIV_W)
	) u_div16 (
		.i_clk_sys (i_clk_sys),
		.i_reset   (i_reset),
		.i_clr     (cnt_clr),
		.i_step    (1'b1),
		.i_modulus (divisor_value),
		.o_wrap    (wrap16)
	);

	sbrg_modcnt #(
		.W(SBRG_OVS_W)
	) u_div_bit (
		.i_clk_sys (i_clk_sys),
		.i_reset   (i_reset),
		.i_clr     (cnt_clr),
		.i_step    (wrap16),
		.i_modulus (SBRG_OVERSAMPLE),
		.o_wrap    (wrap_bit)
	);

	sbrg_flag u_flag_lbk (
		.i_clk_sys (i_clk_sys),
		.i_reset   (i_reset),
		.i_set     (i_line_break_evt),
		.i_clr     (clr_lbk),
		.o_flag    (line_break_flag)
	);

	sbrg_flag u_flag_rxe (
		.i_clk_sys (i_clk_sys),
		.i_reset   (i_reset),
		.i_set     (i_rx_edge_evt),
		.i_clr     (clr_rxe),
		.o_flag    (rx_edge_flag)
	);

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (i_address)
			SBRG_OFS_DIVH: begin
				rd_mux[7:0] = s.divh_buf_ff & SBRG_DIVH_WMASK;
			end
			SBRG_OFS_DIVL: begin
				rd_mux[7:0] = s.divl_ff;
			end
			SBRG_OFS_CTRL: begin
				rd_mux[1:0] = s.ctrl_ff;
			end
			SBRG_OFS_STAT: begin
				rd_mux[SBRG_BIT_LBK_IE] = line_break_flag;
				rd_mux[SBRG_BIT_RXE_IE] = rx_edge_flag;
			end
			SBRG_OFS_GEN: begin
				rd_mux[SBRG_BIT_RUN] = s.run_ff;
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	always_comb begin
		nxt_s = s;
		// Bus handshake
		if (s.wait_ff) begin
			nxt_s.wait_ff = ~req;
			nxt_s.rdata_ff = i_read ? rd_mux : 32'h0000_0000;
		end else begin
			nxt_s.wait_ff = 1'b1;
		end
		// High half only buffered; reserved bit dropped
		if (wr_divh) begin
			nxt_s.divh_buf_ff = i_writedata[7:0] & SBRG_DIVH_WMASK;
		end
		// Low write commits the buffered high half
		if (wr_divl) begin
			nxt_s.divl_ff      = i_writedata[7:0];
			nxt_s.divh_work_ff = s.divh_buf_ff[SBRG_DIVH_W-1:0];
		end
		if (wr_ctrl) begin
			nxt_s.ctrl_ff[SBRG_BIT_RX_ON] = i_writedata[SBRG_BIT_RX_ON];
			nxt_s.ctrl_ff[SBRG_BIT_TX_ON] = i_writedata[SBRG_BIT_TX_ON];
			if (i_writedata[SBRG_BIT_RX_ON] | i_writedata[SBRG_BIT_TX_ON]) begin
				nxt_s.armed_ff = 1'b1;
			end
		end
		// Zero divisor means fully stopped, no switching
		nxt_s.run_ff = s.armed_ff & (divisor_value != '0);
		nxt_s.tick16_ff   = wrap16 & ~cnt_clr;
		nxt_s.bit_tick_ff = wrap_bit & ~cnt_clr;
		nxt_s.irq_ff = (line_break_flag & s.divh_buf_ff[SBRG_BIT_LBK_IE])
			| (rx_edge_flag & s.divh_buf_ff[SBRG_BIT_RXE_IE]);
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			s <= STATE_RST;
		end else begin
			s <= nxt_s;
		end
	end

	assign o_readdata      = s.rdata_ff;
	assign o_waitrequest   = s.wait_ff;
	assign o_irq           = s.irq_ff;
	assign o_tick16        = s.tick16_ff;
	assign o_bit_tick      = s.bit_tick_ff;
	assign o_gen_run       = s.run_ff;
	assign o_divisor_value = divisor_value;
	assign o_rx_on_bit     = s.ctrl_ff[SBRG_BIT_RX_ON];
	assign o_tx_on_bit     = s.ctrl_ff[SBRG_BIT_TX_ON];

	// Period checker helpers
	logic [SBRG_DIV_W-1:0] gap_ff;
	logic                  seen_ff;
	logic [SBRG_OVS_W-1:0] t16_cnt_ff;
	logic                  bit_seen_ff;

	always_ff @(posedge i_clk_sys) begin
		if (i_reset || cnt_clr) begin
			gap_ff      <= '0;
			seen_ff     <= 1'b0;
			t16_cnt_ff  <= '0;
			bit_seen_ff <= 1'b0;
		end else begin
			gap_ff <= o_tick16 ? '0 : gap_ff + SBRG_DIV_W'(1);
			if (o_tick16) begin
				seen_ff <= 1'b1;
			end
			if (o_bit_tick) begin
				// A tick in the same cycle opens the next count
				t16_cnt_ff  <= o_tick16 ? SBRG_OVS_W'(1) : '0;
				bit_seen_ff <= 1'b1;
			end else if (o_tick16) begin
				t16_cnt_ff <= t16_cnt_ff + SBRG_OVS_W'(1);
			end
		end
	end

	high_buffer_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		$changed(s.divh_work_ff) |-> $past(wr_divl))
		else $error("Working high half changed without a low write");

	gen_idle_unarmed_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		!s.armed_ff |-> !o_gen_run && !o_tick16 && !o_bit_tick)
		else $error("Generator ran before being enabled");

	zero_divisor_stop_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(divisor_value == '0) [*3] |-> !o_gen_run && !o_tick16 && !o_bit_tick)
		else $error("Generator active with zero divisor");

	tick_period_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(o_tick16 && seen_ff) |-> (gap_ff == divisor_value - SBRG_DIV_W'(1)))
		else $error("Oversample tick period differs from divisor");

	bit_period_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(o_bit_tick && bit_seen_ff) |-> (t16_cnt_ff == SBRG_OVERSAMPLE))
		else $error("Bit tick is not every sixteen oversample ticks");

	divisor_compose_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		wr_divl |=> (o_divisor_value[7:0] == $past(i_writedata[7:0]))
			&& (o_divisor_value[12:8] == $past(s.divh_buf_ff[4:0])))
		else $error("Divisor not composed from the two halves");

	break_irq_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(line_break_flag && s.divh_buf_ff[SBRG_BIT_LBK_IE]) |=> o_irq)
		else $error("Line break did not raise the interrupt");

	edge_irq_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(rx_edge_flag && s.divh_buf_ff[SBRG_BIT_RXE_IE]) |=> o_irq)
		else $error("Receive edge did not raise the interrupt");

	irq_masked_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		!(line_break_flag && s.divh_buf_ff[SBRG_BIT_LBK_IE])
			&& !(rx_edge_flag && s.divh_buf_ff[SBRG_BIT_RXE_IE]) |=> !o_irq)
		else $error("Interrupt raised without an enabled flag");

	reserved_bit_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		rd_divh |=> !o_readdata[SBRG_BIT_RSVD])
		else $error("Reserved high bit read as one");

	bus_answer_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(req && s.wait_ff) |=> !o_waitrequest ##1 o_waitrequest)
		else $error("Bus answer not one cycle long");

	lane_ignored_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(i_write && !s.wait_ff && !i_byteenable[0]) |=> $stable(s.divl_ff)
			&& $stable(s.divh_buf_ff) && $stable(s.ctrl_ff))
		else $error("Write with lane 0 off changed a register");

	rdata_idle_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(s.wait_ff && !req) |=> (o_readdata == 32'h0000_0000))
		else $error("Read data not cleared when idle");

	arm_on_enable_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(wr_ctrl && (i_writedata[SBRG_BIT_RX_ON] || i_writedata[SBRG_BIT_TX_ON])) |=> s.armed_ff)
		else $error("Enable write did not arm the generator");

	run_follows_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(s.armed_ff && (divisor_value != '0)) |=> o_gen_run)
		else $error("Generator not running although armed with a divisor");

	tick_needs_run_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		o_tick16 |-> $past(o_gen_run))
		else $error("Oversample tick while generator stopped");

	bit_under_tick_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		o_bit_tick |-> $past(o_tick16))
		else $error("Bit tick without a preceding oversample tick");

	flag_stands_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(line_break_flag && !clr_lbk) |=> line_break_flag)
		else $error("Line break flag dropped without a clear");

	ctrl_write_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		wr_ctrl |=> (o_rx_on_bit == $past(i_writedata[SBRG_BIT_RX_ON]))
			&& (o_tx_on_bit == $past(i_writedata[SBRG_BIT_TX_ON])))
		else $error("Control write did not land");

	tick_seen_c: cover property (@(posedge i_clk_sys) disable iff (i_reset)
		o_tick16 && seen_ff);

	bit_tick_c: cover property (@(posedge i_clk_sys) disable iff (i_reset)
		o_bit_tick && bit_seen_ff);

	irq_raise_c: cover property (@(posedge i_clk_sys) disable iff (i_reset)
		!o_irq ##1 o_irq);

	divisor_commit_c: cover property (@(posedge i_clk_sys) disable iff (i_reset)
		wr_divh ##[1:20] wr_divl);

	run_stop_c: cover property (@(posedge i_clk_sys) disable iff (i_reset)
		o_gen_run ##1 !o_gen_run);

endmodule

//--- sim/sbrg_evt_model.sv
module sbrg_evt_model (
	// Clock
	input  wire logic i_clk_sys,
	// Receiver events toward the block
	output logic      o_line_break_evt,
	output logic      o_rx_edge_evt
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		o_line_break_evt = 1'b0;
		o_rx_edge_evt    = 1'b0;
	end

	// One-cycle pulse, launched just after an edge like the real receiver
	task automatic fire(input logic which);
		@(posedge i_clk_sys);
		if (which) begin
			o_rx_edge_evt <= 1'b1;
		end else begin
			o_line_break_evt <= 1'b1;
		end
		@(posedge i_clk_sys);
		o_rx_edge_evt    <= 1'b0;
		o_line_break_evt <= 1'b0;
	endtask
endmodule

//--- sim/sbrg_top_tb.sv
module sbrg_top_tb;
	import sbrg_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic                   i_clk_sys    = 1'b0;
	logic                   i_reset      = 1'b1;
	logic [SBRG_ADDR_W-1:0] i_address    = '0;
	logic                   i_read       = 1'b0;
	logic                   i_write      = 1'b0;
	logic [31:0]            i_writedata  = '0;
	logic [3:0]             i_byteenable = 4'hF;
	logic [31:0]            o_readdata;
	logic                   o_waitrequest;
	logic                   lbk_evt;
	logic                   rxe_evt;
	logic                   o_irq;
	logic                   o_tick16;
	logic                   o_bit_tick;
	logic                   o_gen_run;
	logic [SBRG_DIV_W-1:0]  o_divisor_value;
	logic                   o_rx_on_bit;
	logic                   o_tx_on_bit;
	int                     n_fail     = 0;
	int                     num_checks = 0;
	logic [31:0]            q;
	int                     n16;
	int                     nbit;

	always #12.5 i_clk_sys = ~i_clk_sys;

	sbrg_top dut (
		.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_address(i_address),
		.i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
		.i_byteenable(i_byteenable), .o_readdata(o_readdata),
		.o_waitrequest(o_waitrequest), .i_line_break_evt(lbk_evt),
		.i_rx_edge_evt(rxe_evt), .o_irq(o_irq), .o_tick16(o_tick16),
		.o_bit_tick(o_bit_tick), .o_gen_run(o_gen_run),
		.o_divisor_value(o_divisor_value), .o_rx_on_bit(o_rx_on_bit),
		.o_tx_on_bit(o_tx_on_bit)
	);

	sbrg_evt_model evt (
		.i_clk_sys(i_clk_sys), .o_line_break_evt(lbk_evt), .o_rx_edge_evt(rxe_evt)
	);

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic chk_n(input int got, input int exp, input string msg);
		num_checks++;
		if (got != exp) begin
			n_fail++;
			$display("mismatch at %0t: %s got %0d exp %0d", $time, msg, got, exp);
		end
	endtask

	// Edge first, so a released strobe is never raised again in the same step
	task automatic bus(input logic [4:0] a, input logic wr, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge i_clk_sys);
		i_address   <= a;
		i_write     <= wr;
		i_read      <= !wr;
		i_writedata <= {24'h00_0000, d};
		do begin
			@(posedge i_clk_sys);
			n++;
		end while (o_waitrequest !== 1'b0);
		chk_n(n, 2, "bus answer");
		q = o_readdata;
		i_write <= 1'b0;
		i_read  <= 1'b0;
	endtask

	task automatic count_ticks(input int cyc);
		n16  = 0;
		nbit = 0;
		repeat (cyc) begin
			@(posedge i_clk_sys);
			n16  += (o_tick16 === 1'b1);
			nbit += (o_bit_tick === 1'b1);
		end
	endtask

	// Align on a tick so any window of k*N cycles holds exactly k ticks
	task automatic set_div_and_align(input logic [7:0] hi, input logic [7:0] lo);
		int n;
		n = 0;
		bus(SBRG_OFS_DIVH, 1'b1, hi);
		bus(SBRG_OFS_DIVL, 1'b1, lo);
		do begin
			@(posedge i_clk_sys);
			n++;
		end while (o_tick16 !== 1'b1 && n < 9000);
		chk_n(n < 9000, 1, "first tick");
	endtask

	task automatic t_reset_idle();
		chk(o_divisor_value, 32'h0000_0001, "reset divisor");
		bus(SBRG_OFS_DIVL, 1'b0, 8'h00);
		chk(q, 32'h0000_0001, "low reset");
		bus(5'h14, 1'b0, 8'h00);
		chk(q, 32'h0000_0000, "unmapped read");
		i_byteenable <= 4'hE;
		bus(SBRG_OFS_DIVL, 1'b1, 8'h55);
		i_byteenable <= 4'hF;
		bus(SBRG_OFS_DIVL, 1'b0, 8'h00);
		chk(q, 32'h0000_0001, "lane 0 off ignored");
		count_ticks(100);
		chk_n(n16, 0, "unarmed ticks");
		chk(o_gen_run, 32'h0000_0000, "unarmed run");
	endtask

	task automatic t_buffered_high();
		bus(SBRG_OFS_DIVH, 1'b1, 8'h3F);
		bus(SBRG_OFS_DIVH, 1'b0, 8'h00);
		chk(q, 32'h0000_001F, "reserved bit");
		chk(o_divisor_value, 32'h0000_0001, "high held back");
		bus(SBRG_OFS_DIVL, 1'b1, 8'h34);
		repeat (2) @(posedge i_clk_sys);
		chk(o_divisor_value, 32'h0000_1F34, "divisor joined");
		count_ticks(50);
		chk_n(n16, 0, "still unarmed");
	endtask

	task automatic t_rates();
		bus(SBRG_OFS_CTRL, 1'b1, 8'h03);
		repeat (3) @(posedge i_clk_sys);
		chk(o_rx_on_bit, 32'h0000_0001, "rx on");
		chk(o_tx_on_bit, 32'h0000_0001, "tx on");
		set_div_and_align(8'h00, 8'h02);
		chk(o_gen_run, 32'h0000_0001, "armed run");
		bus(SBRG_OFS_GEN, 1'b0, 8'h00);
		chk(q, 32'h0000_0001, "run readable");
		count_ticks(64);
		chk_n(n16, 32, "tick16 at 2");
		chk_n(nbit, 2, "bit tick at 2");
		// Largest divisor: only the oversample tick fits the run length
		set_div_and_align(8'h1F, 8'hFF);
		count_ticks(16382);
		chk_n(n16, 2, "tick16 at 8191");
		bus(SBRG_OFS_DIVH, 1'b1, 8'h00);
		bus(SBRG_OFS_DIVL, 1'b1, 8'h00);
		repeat (3) @(posedge i_clk_sys);
		chk(o_gen_run, 32'h0000_0000, "zero stops");
		count_ticks(200);
		chk_n(n16 + nbit, 0, "zero ticks");
		bus(SBRG_OFS_GEN, 1'b0, 8'h00);
		chk(q, 32'h0000_0000, "run reads stopped");
	endtask

	task automatic t_irq();
		int b;
		for (int i = 0; i < 2; i++) begin
			b = i ? SBRG_BIT_RXE_IE : SBRG_BIT_LBK_IE;
			bus(SBRG_OFS_DIVH, 1'b1, 8'h00);
			evt.fire(i[0]);
			repeat (3) @(posedge i_clk_sys);
			chk(o_irq, 32'h0000_0000, "masked irq");
			bus(SBRG_OFS_STAT, 1'b0, 8'h00);
			chk(q, 32'h0000_0001 << b, "flag polled");
			bus(SBRG_OFS_DIVH, 1'b1, 8'h01 << b);
			repeat (2) @(posedge i_clk_sys);
			chk(o_irq, 32'h0000_0001, "enabled irq");
			bus(SBRG_OFS_STAT, 1'b1, 8'h01 << b);
			repeat (2) @(posedge i_clk_sys);
			chk(o_irq, 32'h0000_0000, "cleared irq");
			bus(SBRG_OFS_STAT, 1'b0, 8'h00);
			chk(q, 32'h0000_0000, "flag cleared");
		end
	endtask

	// Reset while armed but stopped by the zero divisor must drop the arming again
	task automatic t_reset_again();
		@(posedge i_clk_sys);
		i_reset <= 1'b1;
		repeat (2) @(posedge i_clk_sys);
		i_reset <= 1'b0;
		chk(o_divisor_value, 32'h0000_0001, "divisor after reset");
		chk(o_rx_on_bit, 32'h0000_0000, "rx off after reset");
		count_ticks(100);
		chk_n(n16, 0, "unarmed after reset");
		bus(SBRG_OFS_CTRL, 1'b1, 8'h01);
		repeat (8) @(posedge i_clk_sys);
		count_ticks(32);
		chk_n(n16, 32, "tick16 at 1");
		chk_n(nbit, 2, "bit tick at 1");
	endtask

	initial begin
		repeat (8) @(posedge i_clk_sys);
		i_reset <= 1'b0;
		t_reset_idle();
		t_buffered_high();
		t_rates();
		t_irq();
		t_reset_again();
		summarize();
	end

	// Whole run is about 26000 cycles
	initial begin
		repeat (60000) @(posedge i_clk_sys);
		n_fail++;
		summarize();
	end
endmodule
